//--- prp_pkg.sv
// Constants for the page permission restriction leaf unit.
// Assumes a single 125 MHz core clock and an AXI4-Lite register port.
package prp_pkg;

  // ==========================================================
  // Leaf selection and operand geometry
  localparam logic [63:0] LEAF_CODE     = 64'h0000_0000_0000_000e;
  localparam logic [63:0] INFO_SIZE     = 64'h0000_0000_0000_0040;
  localparam logic [63:0] PAGE_SIZE     = 64'h0000_0000_0000_1000;
  localparam int          INFO_ALIGN_W  = 6;
  localparam int          PAGE_SHIFT    = 12;
  localparam int          CANON_MSB     = 47;

  // ==========================================================
  // Result codes returned in the result code register
  localparam logic [63:0] CODE_OK       = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CODE_LOCKFAIL = 64'h0000_0000_0000_0001;
  localparam logic [63:0] CODE_NOT_MOD  = 64'h0000_0000_0000_0002;

  // ==========================================================
  // Page cache map entry layout (16 bits per page)
  localparam int          E_VALID       = 0;
  localparam int          E_R           = 1;
  localparam int          E_W           = 2;
  localparam int          E_X           = 3;
  localparam int          E_PEND        = 4;
  localparam int          E_MOD         = 5;
  localparam int          E_PR          = 6;
  localparam int          E_PT_LSB      = 8;
  localparam int          E_EID_LSB     = 12;
  localparam int          ENTRY_W       = 16;
  localparam logic [2:0]  PT_REGULAR    = 3'h1;

  // ==========================================================
  // Register map (byte offsets) and reset values
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h0c;
  localparam logic [7:0]  REG_MAP_IDX   = 8'h10;
  localparam logic [7:0]  REG_MAP_DATA  = 8'h14;
  localparam logic [7:0]  REG_ENC_INIT  = 8'h18;
  localparam logic [7:0]  REG_LAST_CODE = 8'h1c;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ==========================================================
  // Interrupt status bits
  localparam int          IRQ_DONE      = 0;
  localparam int          IRQ_GP        = 1;
  localparam int          IRQ_PF        = 2;
  localparam int          IRQ_SOFT      = 3;
  localparam int          IRQ_W         = 4;

  // Leaf sequencer states, Gray along idle-eval-finish
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EVAL = 2'h1,
    ST_FIN  = 2'h3
  } prp_state_t;

  // Outcome of one leaf evaluation
  typedef enum logic [1:0] {
    OUT_OK   = 2'h0,
    OUT_GP   = 2'h1,
    OUT_PF   = 2'h2,
    OUT_SOFT = 2'h3
  } prp_out_t;

endpackage

//--- prp_restrict_unit.sv
// Page permission restriction leaf unit with its page cache map.
// Assumes leaf operands held stable by the core while leaf_ready is low,
// and concurrency status supplied by the neighbouring leaf sequencers.
`timescale 1ns/1ps
`default_nettype none
module prp_restrict_unit #(
  parameter int          NUM_PAGES = 64,
  parameter int          NUM_ENCL  = 16,
  parameter logic [63:0] CACHE_BASE = 64'h0000_0000_8000_0000
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Leaf request from the core
  input  wire logic        leaf_start,
  input  wire logic [63:0] result_code_reg_in,
  input  wire logic [63:0] info_pointer_reg,
  input  wire logic [63:0] page_pointer_reg,
  input  wire logic [1:0]  cur_priv_level,
  input  wire logic        mode_64bit,
  input  wire logic [31:0] data_seg_limit,
  input  wire logic [63:0] info_flags,
  input  wire logic        info_rest_nz,
  // Concurrency status from other leaves on the target page
  input  wire logic        page_add_leaf_busy,
  input  wire logic        page_remove_leaf_busy,
  input  wire logic        page_writeback_leaf_busy,
  input  wire logic        page_augment_leaf_busy,
  input  wire logic        page_load_leaves_busy,
  input  wire logic        page_block_leaf_busy,
  input  wire logic        debug_read_leaf_busy,
  input  wire logic        modify_leaf_busy,
  input  wire logic        epoch_tracking_leaf_busy,
  // Leaf completion
  output logic             leaf_ready,
  output logic             leaf_done,
  output logic [63:0]      result_code_reg,
  output logic             zero_flag,
  output logic             arith_flags_clr,
  output logic             general_protection_fault,
  output logic             page_fault,
  output logic [63:0]      fault_addr,
  output logic             irq,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int IDX_W = $clog2(NUM_PAGES);
  localparam int PT_W  = 3;
  localparam int EID_W = 4;

  // ==========================================================
  // State and storage
  prp_pkg::prp_state_t          state_q;
  logic [prp_pkg::ENTRY_W-1:0]  map_mem [NUM_PAGES]; // Page cache map
  logic [NUM_ENCL-1:0]          enc_init_q;  // Initialized attribute
  logic [31:0]                  ctrl_q;      // Bit 0: gen-2 leaves on
  logic [IDX_W-1:0]             map_idx_q;   // Software map index
  logic [prp_pkg::IRQ_W-1:0]    irq_stat_q;
  logic [prp_pkg::IRQ_W-1:0]    irq_mask_q;
  logic [63:0]                  info_q;      // Scratch copy of info flags
  logic                         rest_nz_q;
  logic [63:0]                  page_q;
  logic [63:0]                  ptr_q;
  logic [1:0]                   cpl_q;
  logic                         m64_q;
  logic [31:0]                  lim_q;

  // ==========================================================
  // Leaf sequencer: take, evaluate, finish
  // accept only the restriction leaf code
  logic take;
  assign take       = leaf_start && (state_q == prp_pkg::ST_IDLE) &&
                      (result_code_reg_in == prp_pkg::LEAF_CODE);
  assign leaf_ready = (state_q == prp_pkg::ST_IDLE);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= prp_pkg::ST_IDLE;
    end else begin
      case (state_q)
        prp_pkg::ST_IDLE: if (take) state_q <= prp_pkg::ST_EVAL;
        prp_pkg::ST_EVAL: state_q <= prp_pkg::ST_FIN;
        default:          state_q <= prp_pkg::ST_IDLE;
      endcase
    end
  end

  // Operand capture; the info flags are copied once to scratch storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      info_q    <= 64'h0;
      rest_nz_q <= 1'b0;
      page_q    <= 64'h0;
      ptr_q     <= 64'h0;
      cpl_q     <= 2'h0;
      m64_q     <= 1'b0;
      lim_q     <= 32'h0;
    end else if (take) begin
      info_q    <= info_flags;
      rest_nz_q <= info_rest_nz;
      page_q    <= page_pointer_reg;
      ptr_q     <= info_pointer_reg;
      cpl_q     <= cur_priv_level;
      m64_q     <= mode_64bit;
      lim_q     <= data_seg_limit;
    end
  end

  // ==========================================================
  // Check evaluation, in the documented priority order
  logic [63:0]                 off;
  logic [IDX_W-1:0]            pidx;
  logic [prp_pkg::ENTRY_W-1:0] ent;
  logic [PT_W-1:0]             ent_pt;
  logic [EID_W-1:0]            ent_eid;
  logic                        in_cache, seg_bad, canon_bad, conflict;
  logic [32:0]                 info_end, page_end;
  prp_pkg::prp_out_t           outc;
  logic [63:0]                 soft_code;

  assign off      = page_q - CACHE_BASE;
  assign pidx     = off[prp_pkg::PAGE_SHIFT +: IDX_W];
  assign in_cache = (page_q >= CACHE_BASE) &&
                    ((off >> prp_pkg::PAGE_SHIFT) < 64'(NUM_PAGES));
  assign ent      = map_mem[pidx];
  assign ent_pt   = ent[prp_pkg::E_PT_LSB +: PT_W];
  assign ent_eid  = ent[prp_pkg::E_EID_LSB +: EID_W];
  // Last byte of each operand against the data segment limit
  assign info_end = {1'b0, ptr_q[31:0]} + 33'(prp_pkg::INFO_SIZE - 64'h1);
  assign page_end = {1'b0, page_q[31:0]} + 33'(prp_pkg::PAGE_SIZE - 64'h1);
  // segment limit in protected mode, canonical form in 64-bit
  assign seg_bad   = !m64_q && ((info_end > {1'b0, lim_q}) ||
                                (page_end > {1'b0, lim_q}));
  assign canon_bad = m64_q &&
    (!(&ptr_q[63:prp_pkg::CANON_MSB] || ~|ptr_q[63:prp_pkg::CANON_MSB]) ||
     !(&page_q[63:prp_pkg::CANON_MSB] || ~|page_q[63:prp_pkg::CANON_MSB]));
  // block and debug-read busy lines are deliberately not refused
  // first-generation and augment leaves on the page refuse
  assign conflict = page_add_leaf_busy || page_remove_leaf_busy ||
                    page_writeback_leaf_busy || page_augment_leaf_busy ||
                    page_load_leaves_busy;

  always_comb begin
    outc      = prp_pkg::OUT_OK;
    soft_code = prp_pkg::CODE_OK;
    // leaf exists only with the gen-2 feature reported
    if (!ctrl_q[0]) begin
      outc = prp_pkg::OUT_GP;
    end else if (cpl_q != 2'h0) begin
      outc = prp_pkg::OUT_GP;
    end else if (seg_bad || canon_bad) begin
      outc = prp_pkg::OUT_GP;
    end else if (ptr_q[prp_pkg::INFO_ALIGN_W-1:0] != '0) begin
      outc = prp_pkg::OUT_GP;
    end else if (page_q[prp_pkg::PAGE_SHIFT-1:0] != '0) begin
      outc = prp_pkg::OUT_GP;
    end else if (!in_cache) begin
      outc = prp_pkg::OUT_PF;
    // reserved fields, write requested without read
    end else if (rest_nz_q || (info_q[63:3] != '0) ||
                 (!info_q[0] && info_q[1])) begin
      outc = prp_pkg::OUT_GP;
    end else if (conflict) begin
      outc = prp_pkg::OUT_GP;
    end else if (!ent[prp_pkg::E_VALID]) begin
      outc = prp_pkg::OUT_PF;
    // another modify leaf holds the page
    end else if (modify_leaf_busy) begin
      outc      = prp_pkg::OUT_SOFT;
      soft_code = prp_pkg::CODE_LOCKFAIL;
    // pending or modified page is not modifiable
    end else if (ent[prp_pkg::E_PEND] || ent[prp_pkg::E_MOD]) begin
      outc      = prp_pkg::OUT_SOFT;
      soft_code = prp_pkg::CODE_NOT_MOD;
    end else if (ent_pt != prp_pkg::PT_REGULAR) begin
      outc = prp_pkg::OUT_PF;
    end else if (!enc_init_q[ent_eid]) begin
      outc = prp_pkg::OUT_GP;
    // epoch tracking on the same enclave
    end else if (epoch_tracking_leaf_busy) begin
      outc = prp_pkg::OUT_GP;
    end
  end

  // ==========================================================
  // Completion outputs, registered, one done pulse per leaf
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      leaf_done                <= 1'b0;
      result_code_reg          <= 64'h0;
      zero_flag                <= 1'b0;
      arith_flags_clr          <= 1'b0;
      general_protection_fault <= 1'b0;
      page_fault               <= 1'b0;
      fault_addr               <= 64'h0;
    end else begin
      leaf_done                <= (state_q == prp_pkg::ST_EVAL);
      arith_flags_clr          <= 1'b0;
      general_protection_fault <= 1'b0;
      page_fault               <= 1'b0;
      if (state_q == prp_pkg::ST_EVAL) begin
        general_protection_fault <= (outc == prp_pkg::OUT_GP);
        page_fault               <= (outc == prp_pkg::OUT_PF);
        fault_addr <= (outc == prp_pkg::OUT_PF) ? page_q : 64'h0;
        // flags on completion, clean or soft failure
        if (outc == prp_pkg::OUT_OK || outc == prp_pkg::OUT_SOFT) begin
          arith_flags_clr <= 1'b1;
          zero_flag       <= (outc == prp_pkg::OUT_SOFT);
          result_code_reg <= soft_code;
        end
      end
    end
  end

  // ==========================================================
  // AXI4-Lite slave; address and data taken together
  logic        wr_go, rd_go;
  logic [31:0] wmask, rd_val;
  logic        rd_hit, wr_hit;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // Write decode flags unmapped offsets for a slave error
  always_comb begin
    if (s_axi_awaddr == prp_pkg::REG_CTRL ||
        s_axi_awaddr == prp_pkg::REG_IRQ_MASK ||
        s_axi_awaddr == prp_pkg::REG_MAP_IDX ||
        s_axi_awaddr == prp_pkg::REG_MAP_DATA ||
        s_axi_awaddr == prp_pkg::REG_ENC_INIT) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Read decode; reserved bits read zero
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    if (s_axi_araddr == prp_pkg::REG_CTRL) begin
      rd_val = ctrl_q;
    end else if (s_axi_araddr == prp_pkg::REG_STATUS) begin
      rd_val = {30'h0, zero_flag, !leaf_ready};
    end else if (s_axi_araddr == prp_pkg::REG_IRQ_STAT) begin
      rd_val = 32'(irq_stat_q);
    end else if (s_axi_araddr == prp_pkg::REG_IRQ_MASK) begin
      rd_val = 32'(irq_mask_q);
    end else if (s_axi_araddr == prp_pkg::REG_MAP_IDX) begin
      rd_val = 32'(map_idx_q);
    end else if (s_axi_araddr == prp_pkg::REG_MAP_DATA) begin
      rd_val = 32'(map_mem[map_idx_q]);
    end else if (s_axi_araddr == prp_pkg::REG_ENC_INIT) begin
      rd_val = 32'(enc_init_q);
    end else if (s_axi_araddr == prp_pkg::REG_LAST_CODE) begin
      rd_val = result_code_reg[31:0];
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Responses stand until the master takes them
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= prp_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= prp_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? prp_pkg::RESP_OKAY : prp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? prp_pkg::RESP_OKAY : prp_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q     <= prp_pkg::CTRL_RST;
      irq_mask_q <= '0;
      map_idx_q  <= '0;
      enc_init_q <= '0;
    end else if (wr_go) begin
      if (s_axi_awaddr == prp_pkg::REG_CTRL) begin
        ctrl_q <= (ctrl_q & ~wmask) | (s_axi_wdata & wmask & 32'h1);
      end else if (s_axi_awaddr == prp_pkg::REG_IRQ_MASK) begin
        irq_mask_q <= s_axi_wdata[prp_pkg::IRQ_W-1:0];
      end else if (s_axi_awaddr == prp_pkg::REG_MAP_IDX) begin
        map_idx_q <= s_axi_wdata[IDX_W-1:0];
      end else if (s_axi_awaddr == prp_pkg::REG_ENC_INIT) begin
        enc_init_q <= s_axi_wdata[NUM_ENCL-1:0];
      end
    end
  end

  // ==========================================================
  // Page cache map update; the leaf commit wins a same-cycle
  // software write to the same entry, which is then lost.
  logic commit;
  logic [prp_pkg::ENTRY_W-1:0] ent_new;
  // commit only after every check passed
  assign commit = (state_q == prp_pkg::ST_EVAL) && (outc == prp_pkg::OUT_OK);
  always_comb begin
    ent_new = ent;
    // restriction pending recorded with the update
    ent_new[prp_pkg::E_PR] = 1'b1;
    // each stored bit ANDed with its mask bit
    ent_new[prp_pkg::E_R] = ent[prp_pkg::E_R] & info_q[0];
    ent_new[prp_pkg::E_W] = ent[prp_pkg::E_W] & info_q[1];
    ent_new[prp_pkg::E_X] = ent[prp_pkg::E_X] & info_q[2];
  end

  always_ff @(posedge clk_sys) begin
    if (commit) begin
      map_mem[pidx] <= ent_new;
    end
    // A software write to any other entry still lands alongside
    if (wr_go && s_axi_awaddr == prp_pkg::REG_MAP_DATA &&
        !(commit && map_idx_q == pidx)) begin
      map_mem[map_idx_q] <= s_axi_wdata[prp_pkg::ENTRY_W-1:0];
    end
  end

  // ==========================================================
  // Interrupts: sticky events, cleared by reading, set wins
  logic [prp_pkg::IRQ_W-1:0] irq_set;
  logic                      stat_rd;
  // Zero flag only holds news on a clean or soft completion; a fault keeps it stale
  assign irq_set = {leaf_done && arith_flags_clr && zero_flag, page_fault,
                    general_protection_fault, leaf_done};
  assign stat_rd = rd_go && (s_axi_araddr == prp_pkg::REG_IRQ_STAT);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | irq_set;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // ==========================================================
  // Checks on the sequencer and the map
  a_done_after_take: assert property (@(posedge clk_sys) disable iff (!nrst)
    take |-> ##2 leaf_done) else $error("done not two cycles after take");
  a_cpl_faults: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && cur_priv_level != 2'h0 |-> ##2 general_protection_fault)
    else $error("nonzero privilege did not fault");
  a_info_align: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && info_pointer_reg[5:0] != 6'h0 |-> ##2
    general_protection_fault) else $error("misaligned info accepted");
  a_page_align: assert property (@(posedge clk_sys) disable iff (!nrst)
    take && page_pointer_reg[11:0] != 12'h0 |-> ##2
    !leaf_done || general_protection_fault || page_fault)
    else $error("misaligned page completed");
  a_wnr_faults: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_q == prp_pkg::ST_EVAL && info_q[1:0] == 2'h2 |=>
    general_protection_fault || page_fault)
    else $error("write without read accepted");
  a_lock_soft: assert property (@(posedge clk_sys) disable iff (!nrst)
    leaf_done && result_code_reg == prp_pkg::CODE_LOCKFAIL &&
    arith_flags_clr |-> zero_flag) else $error("lockfail without zf");
  a_success_zf: assert property (@(posedge clk_sys) disable iff (!nrst)
    commit |=> leaf_done && !zero_flag && arith_flags_clr &&
    result_code_reg == prp_pkg::CODE_OK) else $error("bad success flags");
  a_pr_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    commit |=> map_mem[$past(pidx)][prp_pkg::E_PR])
    else $error("pending bit not set");
  a_perm_narrow: assert property (@(posedge clk_sys) disable iff (!nrst)
    commit |=> map_mem[$past(pidx)][3:1] ==
    ($past(ent[3:1]) & $past(info_q[2:0])))
    else $error("permissions not masked");
  a_fault_no_map: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_q == prp_pkg::ST_EVAL && outc != prp_pkg::OUT_OK && !wr_go
    |=> $stable(map_mem[pidx])) else $error("map changed on fault");
  c_success: cover property (@(posedge clk_sys) disable iff (!nrst) commit);
  c_soft: cover property (@(posedge clk_sys) disable iff (!nrst)
    leaf_done && zero_flag);
  c_pf: cover property (@(posedge clk_sys) disable iff (!nrst) page_fault);
  c_irq: cover property (@(posedge clk_sys) disable iff (!nrst) irq);

endmodule
`default_nettype wire

//--- prp_sw_model.sv
// Software side model that issues the permission restriction leaf.
// Assumes go() is called just after a rising clk_sys edge.
`timescale 1ns/1ps
`default_nettype none
module prp_sw_model (
  input  wire logic   clk_sys,
  output logic        leaf_start,
  output logic [63:0] acc,
  output logic [63:0] info_ptr,
  output logic [63:0] page_ptr,
  output logic [1:0]  priv,
  output logic [63:0] flags
);
  // ====================
  // Idle values; operands stay put after a request until the next one
  // leaf code select
  initial begin
    {leaf_start, info_ptr, page_ptr, priv, flags} = '0;
    acc = prp_pkg::LEAF_CODE;
  end
  task automatic go(input logic [63:0] ip, input logic [63:0] pp,
                    input logic [63:0] fl, input logic [1:0] pl,
                    input logic [63:0] cd);
    {acc, info_ptr, page_ptr, flags, priv} <= {cd, ip, pp, fl, pl};
    leaf_start <= 1'b1;
    @(posedge clk_sys);
    leaf_start <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Random plus corner-case bench for the permission restriction unit.
// Assumes prp_pkg and prp_sw_model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
  num_errors++; $display("Error %s exp %h got %h", n, e, s); end end
module tb_top;
  logic clk_sys = 0, nrst = 0, ls, rdy, dn, zf, afc, gp, pf, irq, bv, rv;
  logic av = 0, wv = 0, bq = 0, arv = 0, rq = 0, awr, wrd, arr;
  logic [63:0] acc, ip, pp, fl, rc, fa;
  logic [1:0]  pl, br, rr;
  logic [8:0]  bsy = '0;
  logic [7:0]  aa = '0, ra = '0;
  logic [31:0] wd = '0, rd, lim = 32'hffff_ffff;
  logic        m64 = 1'b1, rnz = 1'b0, off2 = 1'b0;
  int num_errors = 0, n_compared = 0, cyc = 0;
  always #4 clk_sys = ~clk_sys;
  prp_sw_model i_sw (.clk_sys(clk_sys), .leaf_start(ls), .acc(acc),
    .info_ptr(ip), .page_ptr(pp), .priv(pl), .flags(fl));
  prp_restrict_unit i_dut (.clk_sys(clk_sys), .nrst(nrst), .leaf_start(ls),
    .result_code_reg_in(acc), .info_pointer_reg(ip), .page_pointer_reg(pp),
    .cur_priv_level(pl), .mode_64bit(m64), .data_seg_limit(lim),
    .info_flags(fl), .info_rest_nz(rnz), .page_add_leaf_busy(bsy[0]),
    .page_remove_leaf_busy(bsy[1]), .page_writeback_leaf_busy(bsy[2]),
    .page_augment_leaf_busy(bsy[3]), .page_load_leaves_busy(bsy[4]),
    .page_block_leaf_busy(bsy[5]), .debug_read_leaf_busy(bsy[6]),
    .modify_leaf_busy(bsy[7]), .epoch_tracking_leaf_busy(bsy[8]),
    .leaf_ready(rdy), .leaf_done(dn), .result_code_reg(rc), .zero_flag(zf),
    .arith_flags_clr(afc), .general_protection_fault(gp), .page_fault(pf),
    .fault_addr(fa), .irq(irq), .s_axi_awaddr(aa), .s_axi_awvalid(av),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ra),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rq));
  // ====================
  // Bus tasks; readies checked mid-cycle since they only move at edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {aa, wd, av, wv, bq} <= {a, d, 3'h7};
    do @(negedge clk_sys); while (!(awr && wrd));
    @(posedge clk_sys);
    {av, wv} <= 2'h0;
    do @(negedge clk_sys); while (!bv);
    @(posedge clk_sys);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    {ra, arv, rq} <= {a, 2'h3};
    do @(negedge clk_sys); while (!arr);
    @(posedge clk_sys);
    arv <= 1'b0;
    do @(negedge clk_sys); while (!rv);
    {d, r} = {rd, rr};
    @(posedge clk_sys);
  endtask
  // ====================
  // Outcome model: [18] not-modifiable, [17:16] kind, [15:0] new entry
  function automatic logic [18:0] pred(logic [15:0] e, logic [63:0] i,
    logic [63:0] p, logic [63:0] f, logic [8:0] b, logic [1:0] v);
    if (off2 || v != 0 || i[5:0] != 0 || p[11:0] != 0 || (m64 ?
      (|p[63:47] && !(&p[63:47])) :
      ({1'b0, p[31:0]} + 33'hfff > {1'b0, lim}))) return {3'h1, e};
    if (p < 64'h8000_0000 || p >= 64'h8004_0000) return {3'h2, e};
    if (rnz || f[63:3] != 0 || (f[1] && !f[0]) || b[4:0] != 0)
      return {3'h1, e};
    if (!e[0]) return {3'h2, e};
    if (b[7]) return {3'h3, e};
    if (e[4] || e[5]) return {3'h7, e};
    if (e[10:8] != 3'h1) return {3'h2, e};
    if (e[15:12] != 0 || b[8]) return {3'h1, e};
    return {3'h0, e[15:7], 1'b1, e[5:4], e[3:1] & f[2:0], e[0]};
  endfunction
  task automatic run(input logic [15:0] e, input logic [63:0] i,
    input logic [63:0] p, input logic [63:0] f, input logic [8:0] b,
    input logic [1:0] v);
    logic [18:0] x;
    logic [31:0] d;
    logic [1:0] r;
    wr(prp_pkg::REG_MAP_IDX, {26'h0, p[17:12]});
    wr(prp_pkg::REG_MAP_DATA, {16'h0, e});
    x = pred(e, i, p, f, b, v);
    bsy <= b;
    i_sw.go(i, p, f, v, prp_pkg::LEAF_CODE);
    do @(negedge clk_sys); while (!dn);
    `CHK("gp", x[17:16] == 2'h1, gp)
    `CHK("pf", x[17:16] == 2'h2, pf)
    `CHK("afc", x[17:16] == 2'h0 || x[17:16] == 2'h3, afc)
    if (x[17:16] == 2'h2) `CHK("faddr", p, fa)
    if (x[17:16] == 2'h0) `CHK("rc", prp_pkg::CODE_OK, rc)
    if (x[17:16] == 2'h3) `CHK("rc", x[18] ? prp_pkg::CODE_NOT_MOD :
      prp_pkg::CODE_LOCKFAIL, rc)
    if (x[17] == x[16]) `CHK("zf", x[17], zf)
    @(posedge clk_sys);
    bsy <= '0;
    @(negedge clk_sys);
    `CHK("irq", 1'b1, irq)
    @(posedge clk_sys);
    rdr(prp_pkg::REG_MAP_DATA, d, r);
    `CHK("entry", {16'h0, x[15:0]}, d)
    rdr(prp_pkg::REG_IRQ_STAT, d, r);
    `CHK("stat", {28'h0, x[17:16] == 2'h3, x[17:16] == 2'h2,
      x[17:16] == 2'h1, 1'b1}, d)
    `CHK("irq", 1'b0, irq)
    $display("Test done, kind %0d", x[17:16]);
  endtask
  task automatic end_sim();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog: the full run needs about 900 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] e;
    void'($urandom(60300));
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rdr(prp_pkg::REG_CTRL, d, r);
    `CHK("ctrl", prp_pkg::CTRL_RST, d)
    rdr(8'h20, d, r);
    `CHK("unmapped", prp_pkg::RESP_SLVERR, r)
    wr(8'h20, 32'h0);
    `CHK("bresp", prp_pkg::RESP_SLVERR, br)
    wr(prp_pkg::REG_IRQ_MASK, 32'hf);
    wr(prp_pkg::REG_ENC_INIT, 32'h1);
    // Corners: success, overlap, misaligned, outside, W only, soft paths
    run(16'h010f, 64'h40, 64'h8000_1000, 64'h1, 9'h000, 2'h0);
    run(16'h010f, 64'h80, 64'h8003_f000, 64'h5, 9'h060, 2'h0);
    run(16'h010f, 64'h48, 64'h8000_2000, 64'h7, 9'h000, 2'h0);
    run(16'h010f, 64'h40, 64'h8000_2004, 64'h7, 9'h000, 2'h0);
    run(16'h010f, 64'h00, 64'h8004_0000, 64'h7, 9'h000, 2'h0);
    run(16'h010f, 64'h40, 64'h8000_3000, 64'h2, 9'h000, 2'h0);
    run(16'h012f, 64'h40, 64'h8000_4000, 64'h1, 9'h000, 2'h0);
    run(16'h010f, 64'h40, 64'h8000_5000, 64'h1, 9'h080, 2'h0);
    // Foreign leaf code is ignored: the unit stays ready
    i_sw.go(64'h40, 64'h8000_1000, 64'h7, 2'h0, 64'hf);
    @(negedge clk_sys);
    `CHK("ignored", 1'b1, rdy)
    @(posedge clk_sys);
    // Feature switched off, then protected-mode limit, then scratch rest
    off2 = 1'b1;
    wr(prp_pkg::REG_CTRL, 32'h0);
    run(16'h010f, 64'h40, 64'h8000_1000, 64'h7, 9'h000, 2'h0);
    off2 = 1'b0;
    wr(prp_pkg::REG_CTRL, 32'h1);
    {m64, lim} <= {1'b0, 32'h8000_1fff};
    run(16'h010f, 64'h40, 64'h8000_1000, 64'h7, 9'h000, 2'h0);
    run(16'h010f, 64'h40, 64'h8000_2000, 64'h7, 9'h000, 2'h0);
    {m64, lim, rnz} <= {1'b1, 32'hffff_ffff, 1'b1};
    run(16'h010f, 64'h40, 64'h8000_3000, 64'h7, 9'h000, 2'h0);
    rnz <= 1'b0;
    run(16'h010f, 64'h40, 64'h0001_0000_8000_1000, 64'h7, 9'h000, 2'h0);
    repeat (60) begin
      e = 16'($urandom) & 16'h173f;
      if ($urandom % 4 != 0) e[10:8] = 3'h1;
      if ($urandom % 3 != 0) e[5:4] = 2'h0;
      run(e, ($urandom % 8 == 0) ? 64'h8 : 64'h1c0,
        64'h8000_0000 + 64'(($urandom % 70) << 12),
        ($urandom % 10 == 0) ? 64'h10 : 64'($urandom % 8),
        ($urandom % 3 == 0) ? 9'(9'h1 << ($urandom % 9)) : 9'h0,
        ($urandom % 10 == 0) ? 2'h3 : 2'h0);
    end
    end_sim();
  end
endmodule
`default_nettype wire
